// >>> hdl/tpcs_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - The timer mode register is written and read only by its two dedicated instructions.
// - Assigned to timer0, the prescaler divides by two to the power of rate plus one.
// - Assigned to the watchdog it divides 1:1..1:128 in reset mode, 1:2..1:256 in interrupt mode.
// - The assign bit at bit 3 gives the prescaler to the watchdog when one, else to timer0.
// - Edge select one counts falling edges, zero counts rising edges of the external clock pin.
// - The same edge choice applies when the low oscillator is the timer0 clock.
// - Source select zero takes the instruction clock, else the pin or, with low select, the oscillator.
// - The count register reads the live 8-bit prescaler count, ignores writes, resets to ones.
module tpcs_top (
    input  wire logic                     sys_clk_i,
    input  wire logic                     resetn_i,
    input  wire logic                     mode_wr_i,
    input  wire logic [7:0]               mode_wdata_i,
    input  wire logic                     mode_rd_i,
    output var  logic [7:0]               mode_rdata_o,
    input  wire logic                     sfr_rd_i,
    input  wire logic                     sfr_wr_i,
    input  wire logic [tpcs_pkg::ADDR_W-1:0] sfr_addr_i,
    input  wire logic [7:0]               sfr_wdata_i,
    output var  logic [7:0]               sfr_rdata_o,
    input  wire logic                     instr_clk_tick_i,
    input  wire logic                     ext_clock_pin_i,
    input  wire logic                     low_osc_i,
    input  wire logic                     wdt_clk_tick_i,
    input  wire logic                     wdt_int_mode_i,
    output var  logic                     timer0_tick_o,
    output var  logic                     wdt_tick_o
);
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [7:0] mode_rdata_q;
    logic [7:0] mode_rdata_d;
    logic [7:0] sfr_rdata_q;
    logic [7:0] sfr_rdata_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       t0_tick_q;
    logic       t0_tick_d;
    logic       wdt_tick_q;
    logic       wdt_tick_d;
    logic       to_wdt;
    logic [2:0] rate;
    logic       presc_in;
    logic [3:0] shift;
    logic [7:0] mask;
    logic       presc_tick;

    tpcs_clk_if cif ();

    ////////////////////////////////////////////////////////////////////////////
    // mode fields out to the prescaler and the source selector
    assign to_wdt         = mode_q[tpcs_pkg::ASSIGN_BIT];
    assign rate           = mode_q[tpcs_pkg::RATE_LSB +: tpcs_pkg::RATE_W];
    assign cif.source_sel = mode_q[tpcs_pkg::SOURCE_BIT];
    assign cif.low_sel    = mode_q[tpcs_pkg::LOW_CLOCK_BIT];
    assign cif.edge_fall  = mode_q[tpcs_pkg::EDGE_BIT];

    tpcs_edge_sel i_tpcs_edge_sel (
        .sys_clk_i        (sys_clk_i),
        .resetn_i         (resetn_i),
        .instr_clk_tick_i (instr_clk_tick_i),
        .ext_clock_pin_i  (ext_clock_pin_i),
        .low_osc_i        (low_osc_i),
        .cif              (cif.sel_mp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // mode register, reached only by the write and read instructions
    always_comb begin
        mode_d       = mode_q;
        mode_rdata_d = mode_rdata_q;
        if (mode_wr_i) begin
            mode_d = mode_wdata_i;
        end
        if (mode_rd_i) begin
            mode_rdata_d = mode_q;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            mode_q       <= tpcs_pkg::MODE_RESET;
            mode_rdata_q <= tpcs_pkg::MODE_RESET;
        end else begin
            mode_q       <= mode_d;
            mode_rdata_q <= mode_rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared prescaler; the consumer without it sees its source edges directly
    always_comb begin
        presc_in = to_wdt ? wdt_clk_tick_i : cif.edge_pulse;
        if (to_wdt && !wdt_int_mode_i) begin
            shift = {1'b0, rate};
        end else begin
            shift = {1'b0, rate} + 4'h1;
        end
        mask  = ~(8'hFF << shift);
        cnt_d = cnt_q;
        if (presc_in) begin
            cnt_d = cnt_q + 8'h01;
        end
        presc_tick = presc_in && ((cnt_d & mask) == 8'h00);
        t0_tick_d  = to_wdt ? cif.edge_pulse : presc_tick;
        wdt_tick_d = to_wdt ? presc_tick : wdt_clk_tick_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            cnt_q      <= tpcs_pkg::COUNT_RESET;
            t0_tick_q  <= 1'b0;
            wdt_tick_q <= 1'b0;
        end else begin
            cnt_q      <= cnt_d;
            t0_tick_q  <= t0_tick_d;
            wdt_tick_q <= wdt_tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // count register read port; writes fall on nothing
    always_comb begin
        sfr_rdata_d = sfr_rdata_q;
        if (sfr_rd_i) begin
            if (sfr_addr_i == tpcs_pkg::COUNT_ADDR) begin
                sfr_rdata_d = cnt_q;
            end else begin
                sfr_rdata_d = tpcs_pkg::UNMAPPED_RDATA;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            sfr_rdata_q <= tpcs_pkg::UNMAPPED_RDATA;
        end else begin
            sfr_rdata_q <= sfr_rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign mode_rdata_o  = mode_rdata_q;
    assign sfr_rdata_o   = sfr_rdata_q;
    assign timer0_tick_o = t0_tick_q;
    assign wdt_tick_o    = wdt_tick_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    mode_read_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (mode_wr_i ##1 (mode_rd_i && !mode_wr_i)) |=> (mode_rdata_o == $past(mode_wdata_i, 2)))
        else $error("mode read does not return last instruction write");
    count_read_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (sfr_rd_i && sfr_addr_i == tpcs_pkg::COUNT_ADDR) |=> (sfr_rdata_o == $past(cnt_q)))
        else $error("count read not live");
    count_ro_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (sfr_wr_i && !presc_in) |=> $stable(cnt_q))
        else $error("count changed by a write");
    count_step_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        presc_in |=> (cnt_q == $past(cnt_q) + 8'h01))
        else $error("prescaler missed an input edge");
    t0_ratio_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (timer0_tick_o && !$past(to_wdt))
        |-> ((cnt_q & (8'hFF >> (3'h7 - $past(rate)))) == 8'h00))
        else $error("timer0 tick off its ratio");
    wdt_ratio_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (wdt_tick_o && $past(to_wdt) && !$past(wdt_int_mode_i))
        |-> ((cnt_q & (8'h7F >> (3'h7 - $past(rate)))) == 8'h00))
        else $error("watchdog reset mode tick off its ratio");
    wdt_direct_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (!to_wdt && wdt_clk_tick_i) |=> wdt_tick_o)
        else $error("watchdog source lost while prescaler is on timer0");
    t0_direct_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (to_wdt && cif.edge_pulse) |=> (timer0_tick_o && $stable(cnt_q) == !$past(presc_in)))
        else $error("timer0 edge not passed directly");

    // checks on the instruction and register ports
    mode_load_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        mode_wr_i |=> (mode_q == $past(mode_wdata_i)))
        else $error("mode write not taken");
    mode_keep_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !mode_wr_i |=> $stable(mode_q))
        else $error("mode changed without a write instruction");
    mode_hold_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !mode_rd_i |=> $stable(mode_rdata_o))
        else $error("mode read data moved without a read");
    mode_reset_a : assert property (@(posedge sys_clk_i)
        !resetn_i |=> (mode_q == tpcs_pkg::MODE_RESET))
        else $error("mode register not at its reset value");
    unmapped_read_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (sfr_rd_i && sfr_addr_i != tpcs_pkg::COUNT_ADDR)
        |=> (sfr_rdata_o == tpcs_pkg::UNMAPPED_RDATA))
        else $error("unmapped read not zero");
    sfr_hold_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("register read data moved without a read");
    count_reset_a : assert property (@(posedge sys_clk_i)
        !resetn_i |=> (cnt_q == tpcs_pkg::COUNT_RESET))
        else $error("count not all ones after reset");

    // checks on the prescaler and the ticks
    count_idle_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !presc_in |=> $stable(cnt_q))
        else $error("count moved without an input edge");
    t0_gated_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (!to_wdt && !cif.edge_pulse) |=> !timer0_tick_o)
        else $error("timer0 tick without a source edge");
    wdt_gated_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (to_wdt && !wdt_clk_tick_i) |=> !wdt_tick_o)
        else $error("watchdog tick without a base tick");
    wdt_int_ratio_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (wdt_tick_o && $past(to_wdt) && $past(wdt_int_mode_i))
        |-> ((cnt_q & (8'hFF >> (3'h7 - $past(rate)))) == 8'h00))
        else $error("watchdog interrupt mode tick off its ratio");
    t0_half_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (!to_wdt && cif.edge_pulse && rate == 3'h0 && cnt_q[0]) |=> timer0_tick_o)
        else $error("timer0 missed a tick at one to two");
    wdt_one_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (to_wdt && !wdt_int_mode_i && rate == 3'h0 && wdt_clk_tick_i) |=> wdt_tick_o)
        else $error("watchdog missed a tick at one to one");
    tick_reset_a : assert property (@(posedge sys_clk_i)
        !resetn_i |=> (!timer0_tick_o && !wdt_tick_o))
        else $error("tick seen after a reset edge");
endmodule : tpcs_top
`default_nettype wire

// >>> inc/tpcs_pkg.sv
`default_nettype none
// shared constants of the timer0 clock select and prescaler block
package tpcs_pkg;
    // special function register bus
    localparam int         ADDR_W          = 8;
    localparam logic [7:0] COUNT_ADDR      = 8'h0A;   // prescaler_zero_count, read only
    localparam logic [7:0] UNMAPPED_RDATA  = 8'h00;

    // timer_zero_mode field positions
    localparam int         LOW_CLOCK_BIT   = 7;       // low_clock_select
    localparam int         SPARE_BIT       = 6;       // spare_bit, plain storage
    localparam int         SOURCE_BIT      = 5;       // tick_source_select
    localparam int         EDGE_BIT        = 4;       // tick_edge_select
    localparam int         ASSIGN_BIT      = 3;       // prescaler_assign
    localparam int         RATE_LSB        = 0;       // prescaler_rate [2:0]
    localparam int         RATE_W          = 3;

    // reset values
    localparam logic [7:0] MODE_RESET      = 8'h3F;
    localparam logic [7:0] COUNT_RESET     = 8'hFF;
endpackage : tpcs_pkg
`default_nettype wire

// >>> inc/tpcs_clk_if.sv
`timescale 1ns/1ps
`default_nettype none
// timer0 clock source configuration and the selected edge pulse
interface tpcs_clk_if;
    logic source_sel;   // 0 instruction clock, 1 pin or low oscillator
    logic low_sel;      // with source_sel, low oscillator replaces the pin
    logic edge_fall;    // 1 falling edges count, 0 rising edges count
    logic edge_pulse;   // one cycle per counted edge of the selected source

    modport ctrl_mp (output source_sel, output low_sel, output edge_fall, input edge_pulse);
    modport sel_mp  (input source_sel, input low_sel, input edge_fall, output edge_pulse);
endinterface : tpcs_clk_if
`default_nettype wire

// >>> hdl/tpcs_edge_sel.sv
`timescale 1ns/1ps
`default_nettype none
// picks timer0's clock source and turns the chosen edge into a one-cycle pulse
module tpcs_edge_sel (
    input  wire logic     sys_clk_i,
    input  wire logic     resetn_i,
    input  wire logic     instr_clk_tick_i,
    input  wire logic     ext_clock_pin_i,
    input  wire logic     low_osc_i,
    tpcs_clk_if.sel_mp    cif
);
    logic pin_q;
    logic pin_d;
    logic osc_q;
    logic osc_d;
    logic raw_now;
    logic raw_prev;

    ////////////////////////////////////////////////////////////////////////////
    // edge detection; both levels are kept so a source switch sees its own past
    always_comb begin
        pin_d    = ext_clock_pin_i;
        osc_d    = low_osc_i;
        raw_now  = cif.low_sel ? low_osc_i : ext_clock_pin_i;
        raw_prev = cif.low_sel ? osc_q : pin_q;
        if (!cif.source_sel) begin
            cif.edge_pulse = instr_clk_tick_i;
        end else if (cif.edge_fall) begin
            cif.edge_pulse = raw_prev & ~raw_now;
        end else begin
            cif.edge_pulse = ~raw_prev & raw_now;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            pin_q <= 1'b0;
            osc_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
            osc_q <= osc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    pin_fall_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (cif.source_sel && !cif.low_sel && cif.edge_fall && $past(resetn_i)
         && $fell(ext_clock_pin_i)) |-> cif.edge_pulse)
        else $error("falling pin edge not counted");
    pin_rise_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (cif.source_sel && !cif.low_sel && !cif.edge_fall && $fell(ext_clock_pin_i))
        |-> !cif.edge_pulse)
        else $error("falling pin edge counted in rising mode");
    low_osc_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (cif.source_sel && cif.low_sel && cif.edge_fall && $past(resetn_i)
         && $fell(low_osc_i)) |-> cif.edge_pulse)
        else $error("falling low oscillator edge not counted");
    instr_src_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !cif.source_sel |-> (cif.edge_pulse == instr_clk_tick_i))
        else $error("instruction clock not passed through");
    pin_up_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (cif.source_sel && !cif.low_sel && !cif.edge_fall && $past(resetn_i)
         && $rose(ext_clock_pin_i)) |-> cif.edge_pulse)
        else $error("rising pin edge not counted");
    osc_up_a : assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (cif.source_sel && cif.low_sel && !cif.edge_fall && $past(resetn_i)
         && $rose(low_osc_i)) |-> cif.edge_pulse)
        else $error("rising low oscillator edge not counted");
endmodule : tpcs_edge_sel
`default_nettype wire

// >>> testbench/tpcs_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: external clock pin and low oscillator, both idle low
// levels move only when the bench asks, just after a falling clock edge
module tpcs_src_model (
    output var logic pin_o,
    output var logic osc_o
);
    initial begin
        pin_o = 1'b0;
        osc_o = 1'b0;
    end

    // flips one source level and hands back the new level
    task automatic toggle(input logic sel, output logic lvl);
        if (sel) begin
            osc_o = ~osc_o;
            lvl   = osc_o;
        end else begin
            pin_o = ~pin_o;
            lvl   = pin_o;
        end
    endtask
endmodule // tpcs_src_model
`default_nettype wire

// >>> testbench/tpcs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tpcs_tb;
    logic       sys_clk_i = 1'b0;
    logic       resetn_i  = 1'b0;
    logic       mode_wr   = 1'b0;
    logic       mode_rd   = 1'b0;
    logic       sfr_rd    = 1'b0;
    logic       sfr_wr    = 1'b0;
    logic       instr     = 1'b0;
    logic       wdt_t     = 1'b0;
    logic       wdt_int   = 1'b0;
    logic [7:0] mode_wd   = 8'h00;
    logic [7:0] addr      = 8'h00;
    logic [7:0] sfr_wd    = 8'h00;
    logic [7:0] mode_m    = 8'h3F;
    logic [7:0] cnt       = 8'hFF;
    logic [7:0] mode_rdata;
    logic [7:0] sfr_rdata;
    wire logic  pin;
    wire logic  osc;
    logic       t0_tick;
    logic       wdt_tick;
    int         error_cnt = 0;
    int         cmp_count = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;

    tpcs_src_model i_tpcs_src_model (.pin_o(pin), .osc_o(osc));

    tpcs_top i_tpcs_top (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .mode_wr_i(mode_wr),
        .mode_wdata_i(mode_wd), .mode_rd_i(mode_rd), .mode_rdata_o(mode_rdata),
        .sfr_rd_i(sfr_rd), .sfr_wr_i(sfr_wr), .sfr_addr_i(addr), .sfr_wdata_i(sfr_wd),
        .sfr_rdata_o(sfr_rdata), .instr_clk_tick_i(instr), .ext_clock_pin_i(pin),
        .low_osc_i(osc), .wdt_clk_tick_i(wdt_t), .wdt_int_mode_i(wdt_int),
        .timer0_tick_o(t0_tick), .wdt_tick_o(wdt_tick));

    ////////////////////////////////////////////////////////////////////////
    // verdict and counts
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // mode instructions and register bus cycles, one strobe cycle each
    task automatic wmode(input logic [7:0] v);
        @(negedge sys_clk_i);
        mode_wr = 1'b1;
        mode_wd = v;
        @(negedge sys_clk_i);
        mode_wr = 1'b0;
        mode_m  = v;
    endtask

    // read strobe rises at once, right after the caller's closing falling edge
    task automatic rmode;
        mode_rd = 1'b1;
        @(negedge sys_clk_i);
        mode_rd = 1'b0;
        chk(mode_rdata, mode_m, "mode read");
    endtask

    task automatic rsfr(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk_i);
        sfr_rd = 1'b1;
        addr   = a;
        @(negedge sys_clk_i);
        sfr_rd = 1'b0;
        chk(sfr_rdata, exp, "sfr read");
    endtask

    // one source event: 0 instr tick, 1 pin flip, 2 osc flip, 3 watchdog tick
    task automatic step(input int which);
        logic lvl;
        logic e0;
        logic ew;
        logic pt;
        int   n;
        lvl = 1'b0;
        pt  = 1'b0;
        @(negedge sys_clk_i);
        case (which)
            0: instr = 1'b1;
            1: i_tpcs_src_model.toggle(1'b0, lvl);
            2: i_tpcs_src_model.toggle(1'b1, lvl);
            default: wdt_t = 1'b1;
        endcase
        e0 = !mode_m[5] ? (which == 0)
                        : (which == (mode_m[7] ? 2 : 1)) && (lvl != mode_m[4]);
        ew = (which == 3);
        // prescaler model: count the owner's edges, tick on aligned count
        if (mode_m[3] ? ew : e0) begin
            cnt++;
            n  = mode_m[2:0] + ((mode_m[3] && !wdt_int) ? 0 : 1);
            pt = (int'(cnt) % (1 << n)) == 0;
        end
        @(negedge sys_clk_i);
        instr = 1'b0;
        wdt_t = 1'b0;
        chk({6'h00, t0_tick, wdt_tick},
            {6'h00, mode_m[3] ? e0 : e0 && pt, mode_m[3] ? ew && pt : ew},
            "ticks");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        rmode;
        rsfr(8'h0A, 8'hFF);
        rsfr(8'h55, 8'h00);
        @(negedge sys_clk_i);
        sfr_wr = 1'b1;
        addr   = 8'h0A;
        sfr_wd = 8'h12;
        @(negedge sys_clk_i);
        sfr_wr = 1'b0;
        rsfr(8'h0A, 8'hFF);
        $display("reset and access test done");
        for (int r = 0; r < 8; r++) begin
            wmode(8'h00 | 8'(r));
            rmode;
            repeat ((2 << r) + 1) step(0);
            step(3);
            rsfr(8'h0A, cnt);
        end
        $display("timer0 rate test done");
        for (int m = 0; m < 2; m++) begin
            wdt_int = m[0];
            for (int r = 0; r < 8; r++) begin
                wmode(8'h08 | 8'(r));
                rmode;
                repeat ((2 << r) + 1) step(3);
                step(0);
                rsfr(8'h0A, cnt);
            end
        end
        $display("watchdog rate test done");
        for (int c = 0; c < 4; c++) begin
            wmode({c[1], c[0], 1'b1, c[0], 4'h8});
            rmode;
            repeat (2) begin
                step(1);
                step(2);
            end
            step(0);
        end
        $display("source and edge test done");
        end_of_test;
    end

    // cuts a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        end_of_test;
    end
endmodule // tpcs_tb
`default_nettype wire
